// >>> hw/lpmc_pkg.sv
// Package of constants and types for the low-power mode controller
package lpmc_pkg;

   // ----------------------------------------------------------------
   // Mode request codes
   // ----------------------------------------------------------------
   localparam logic [3:0] LPMC_REQ_NONE      = 4'h0;
   localparam logic [3:0] LPMC_REQ_SLEEP     = 4'h1;
   localparam logic [3:0] LPMC_REQ_LP_RUN    = 4'h2;
   localparam logic [3:0] LPMC_REQ_LP_SLEEP  = 4'h3;
   localparam logic [3:0] LPMC_REQ_STOP0     = 4'h4;
   localparam logic [3:0] LPMC_REQ_STOP1     = 4'h5;
   localparam logic [3:0] LPMC_REQ_STOP2     = 4'h6;
   localparam logic [3:0] LPMC_REQ_STANDBY   = 4'h7;
   localparam logic [3:0] LPMC_REQ_SHUTDOWN  = 4'h8;
   localparam logic [3:0] LPMC_REQ_RUN       = 4'h9;

   // ----------------------------------------------------------------
   // Mode states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [9:0] {
      LPMC_RUN      = 10'h001,
      LPMC_SLEEP    = 10'h002,
      LPMC_LP_RUN   = 10'h004,
      LPMC_LP_SLEEP = 10'h008,
      LPMC_STOP0    = 10'h010,
      LPMC_STOP1    = 10'h020,
      LPMC_STOP2    = 10'h040,
      LPMC_STANDBY  = 10'h080,
      LPMC_SHUTDOWN = 10'h100,
      LPMC_WAKE     = 10'h200
   } lpmc_state_t;

   // ----------------------------------------------------------------
   // System clock source codes
   // ----------------------------------------------------------------
   localparam logic [1:0] LPMC_SRC_MRC       = 2'h0;
   localparam logic [1:0] LPMC_SRC_RC16      = 2'h1;
   localparam logic [1:0] LPMC_SRC_NONE      = 2'h3;

   // Frequency ranges of the multispeed RC
   localparam logic [3:0] LPMC_MRC_4MHZ      = 4'h6;
   localparam logic [3:0] LPMC_MRC_48MHZ     = 4'hb;

   // Voltage range codes
   localparam logic       LPMC_RANGE1        = 1'b0;

   // Low-power run ceiling, in kHz
   localparam int         LPMC_SLOW_MAX_KHZ  = 2000;
   localparam logic [15:0] LPMC_SLOW_MAX     = 16'(LPMC_SLOW_MAX_KHZ);

   // Wakeup source count
   localparam int         LPMC_NWAKE         = 8;

   // Retention register width, in bits
   localparam int         LPMC_RET_RANK      = 2;

endpackage

// >>> hw/lpmc_ret_reg.sv
// Small retention register holding control bits across low-power modes
`timescale 1ns/1ps

module lpmc_ret_reg
   import lpmc_pkg::*;
(
   // Clock and reset
   input  wire logic                      clock_i,
   input  wire logic                      rstn_i,
   // Write side
   input  wire logic                      wr_en_i,
   input  wire logic [LPMC_RET_RANK-1:0]  wr_data_i,
   // Read side
   output logic      [LPMC_RET_RANK-1:0]  rd_data_o
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Reset clears: linear regulator and no retention by default
   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
         rd_data_o <= '0;
      else if (wr_en_i)
         rd_data_o <= wr_data_i;
   end

endmodule

// >>> hw/lpmc_top.sv
// Low-power mode sequencer: mode states, clock, regulator and retention controls
`timescale 1ns/1ps

// Operation
// R1 - After any reset start in Run mode at voltage range 1.
// R2 - Sleep gates the CPU clock; peripherals run and may wake it.
// R3 - Low-power run allowed only below 2 MHz; low-power regulator on.
// R4 - Low-power sleep entered only from low-power run.
// R5 - Stop 0/1 retain RAM; stop fast oscillators and PLL; slow ones may run.
// R6 - In Stop modes a wakeup peripheral may request the 16 MHz RC.
// R7 - Stop 0 keeps main regulator; Stop 1 uses low-power regulator.
// R8 - Stop 0/1 exit clock is multispeed RC or 16 MHz RC per software.
// R9 - Stop 2 powers off part of the core domain; RAM and CPU kept.
// R10 - Stop 2 exit clock is multispeed RC or 16 MHz RC per software.
// R11 - Standby powers core off; retain bit keeps second bank on low-power regulator.
// R12 - Standby with detector enabled keeps it on at lowest threshold.
// R13 - Standby exit clock is multispeed RC at 4 MHz.
// R14 - Shutdown disables slow internal RC too; only slow crystal may run.
// R15 - Shutdown exit clock is multispeed RC at 4 MHz.
// R16 - Shutdown disables supply monitoring.
// R17 - Real-time clock may stay active in Stop and Standby.
// R18 - Radio may stay active in Stop modes.
// R19 - On exit except Shutdown, converter restored to converter-select choice.
// R20 - After power-on or pin reset, linear regulator mode selected.
// R21 - Enter low power only on software request; leave on enabled wakeup.
module lpmc_top
   import lpmc_pkg::*;
(
   // Clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    rstn_i,
   // Software controls
   input  wire logic                    mode_req_i,
   input  wire logic [3:0]              mode_sel_i,
   input  wire logic                    wake_on_hsi_i,
   input  wire logic [15:0]             sysclk_khz_i,
   input  wire logic                    standby_ram_retain_bit_i,
   input  wire logic                    vdet_en_i,
   input  wire logic                    rtc_keep_i,
   input  wire logic                    radio_keep_i,
   input  wire logic                    slow_xo_keep_i,
   input  wire logic                    slow_rc_keep_i,
   input  wire logic                    converter_select_bit_i,
   input  wire logic                    converter_wr_i,
   // Wakeup
   input  wire logic [LPMC_NWAKE-1:0]   wake_src_i,
   input  wire logic [LPMC_NWAKE-1:0]   wake_en_i,
   input  wire logic                    wake_hsi_req_i,
   // Mode status
   output lpmc_state_t                  mode_o,
   output logic                         cpu_clk_en_o,
   output logic                         core_clk_en_o,
   output logic                         range_o,
   // Oscillators
   output logic                         pll_en_o,
   output logic                         multispeed_internal_rc_en_o,
   output logic [3:0]                   mrc_range_o,
   output logic                         internal_16mhz_rc_en_o,
   output logic                         external_32mhz_osc_en_o,
   output logic                         low_speed_internal_rc_en_o,
   output logic                         low_speed_external_osc_en_o,
   output logic [1:0]                   sysclk_src_o,
   // Power
   output logic                         main_reg_en_o,
   output logic                         lp_reg_en_o,
   output logic                         core_part_off_o,
   output logic                         core_supply_domain_off_o,
   output logic                         first_ram_bank_keep_o,
   output logic                         second_ram_bank_keep_o,
   output logic                         converter_smps_o,
   // Monitors and always-on blocks
   output logic                         programmable_voltage_detector_en_o,
   output logic                         vdet_lowest_o,
   output logic                         supply_mon_en_o,
   output logic                         rtc_en_o,
   output logic                         radio_en_o
);

   // ----------------------------------------------------------------
   // State and retained control
   // ----------------------------------------------------------------
   lpmc_state_t state_q, state_d;
   lpmc_state_t from_q,  from_d;
   lpmc_state_t prev_q;
   logic [LPMC_RET_RANK-1:0] ret_q;
   logic        exit_hsi_q;

   // Retained converter choice; reset picks linear regulator
   lpmc_ret_reg u_ret (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .wr_en_i   (converter_wr_i),
      .wr_data_i ({standby_ram_retain_bit_i, converter_select_bit_i}),
      .rd_data_o (ret_q)
   ); // R20

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Any enabled wakeup source
   wire wake_hit  = |(wake_src_i & wake_en_i); // R21
   wire slow_ok   = (sysclk_khz_i < LPMC_SLOW_MAX); // R3
   wire in_lp     = state_q inside {LPMC_SLEEP, LPMC_LP_SLEEP, LPMC_STOP0, LPMC_STOP1,
                                    LPMC_STOP2, LPMC_STANDBY, LPMC_SHUTDOWN};

   function automatic logic is_stop(input lpmc_state_t s);
      is_stop = (s == LPMC_STOP0) || (s == LPMC_STOP1) || (s == LPMC_STOP2);
   endfunction

   wire stop_next  = is_stop(state_d);
   wire stby_next  = (state_d == LPMC_STANDBY);
   wire shut_next  = (state_d == LPMC_SHUTDOWN);
   wire down_next  = stby_next | shut_next;

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------
   // Requests are only honoured from a running state; wakeup from sleep
   // states passes through the wake state so clock selection settles.
   always_comb
   begin
      state_d = state_q;
      from_d  = from_q;
      unique case (state_q)
         LPMC_RUN:
         begin
            if (mode_req_i) // R21
            begin
               unique case (mode_sel_i)
                  LPMC_REQ_SLEEP:    state_d = LPMC_SLEEP; // R2
                  LPMC_REQ_LP_RUN:   state_d = slow_ok ? LPMC_LP_RUN : LPMC_RUN; // R3
                  LPMC_REQ_STOP0:    state_d = LPMC_STOP0;
                  LPMC_REQ_STOP1:    state_d = LPMC_STOP1;
                  LPMC_REQ_STOP2:    state_d = LPMC_STOP2;
                  LPMC_REQ_STANDBY:  state_d = LPMC_STANDBY;
                  LPMC_REQ_SHUTDOWN: state_d = LPMC_SHUTDOWN;
                  default:           state_d = LPMC_RUN; // R4
               endcase
               from_d = LPMC_RUN;
            end
         end
         LPMC_LP_RUN:
         begin
            if (!slow_ok || (mode_req_i && mode_sel_i == LPMC_REQ_RUN))
               state_d = LPMC_RUN; // R3
            else if (mode_req_i)
            begin
               unique case (mode_sel_i)
                  LPMC_REQ_LP_SLEEP: state_d = LPMC_LP_SLEEP; // R4
                  LPMC_REQ_STOP1:    state_d = LPMC_STOP1;
                  LPMC_REQ_STOP2:    state_d = LPMC_STOP2;
                  LPMC_REQ_STANDBY:  state_d = LPMC_STANDBY;
                  LPMC_REQ_SHUTDOWN: state_d = LPMC_SHUTDOWN;
                  default:           state_d = LPMC_LP_RUN;
               endcase
               from_d = LPMC_LP_RUN;
            end
         end
         LPMC_SLEEP, LPMC_LP_SLEEP, LPMC_STOP0, LPMC_STOP1, LPMC_STOP2,
         LPMC_STANDBY, LPMC_SHUTDOWN:
         begin
            if (wake_hit)
               state_d = LPMC_WAKE; // R21
         end
         LPMC_WAKE:
         begin
            // Sleep returns to the run flavour it left; deeper modes to Run
            state_d = (from_q == LPMC_LP_RUN && prev_q == LPMC_LP_SLEEP) ? LPMC_LP_RUN
                                                                         : LPMC_RUN;
         end
         default:
            state_d = LPMC_RUN;
      endcase
   end

   // Remember a Stop visit until the wake state picks the exit clock;
   // the wake state cannot see the mode it left, hence prev_q as well
   logic lp_origin_q;

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
      begin
         state_q     <= LPMC_RUN; // R1
         from_q      <= LPMC_RUN;
         prev_q      <= LPMC_RUN;
         exit_hsi_q  <= 1'b0;
         lp_origin_q <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         from_q      <= from_d;
         prev_q      <= state_q;
         exit_hsi_q  <= wake_on_hsi_i;
         lp_origin_q <= (state_q == LPMC_WAKE) ? 1'b0 : (lp_origin_q | stop_next);
      end
   end

   // ----------------------------------------------------------------
   // Output decode for the next state
   // ----------------------------------------------------------------
   wire run_like   = (state_d == LPMC_RUN) || (state_d == LPMC_LP_RUN);
   wire sleep_like = (state_d == LPMC_SLEEP) || (state_d == LPMC_LP_SLEEP);
   wire lp_regime  = (state_d == LPMC_LP_RUN) || (state_d == LPMC_LP_SLEEP);
   wire fast_off   = stop_next | down_next; // R5 R9
   wire retain_b2  = stby_next & ret_q[1]; // R11
   wire wake_deep  = (prev_q == LPMC_STANDBY) || (prev_q == LPMC_SHUTDOWN);
   wire waking     = (state_q == LPMC_WAKE);

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
      begin
         mode_o                             <= LPMC_RUN;
         cpu_clk_en_o                       <= 1'b1;
         core_clk_en_o                      <= 1'b1;
         range_o                            <= LPMC_RANGE1; // R1
         pll_en_o                           <= 1'b0;
         multispeed_internal_rc_en_o        <= 1'b1;
         mrc_range_o                        <= LPMC_MRC_4MHZ;
         internal_16mhz_rc_en_o             <= 1'b0;
         external_32mhz_osc_en_o            <= 1'b0;
         low_speed_internal_rc_en_o         <= 1'b0;
         low_speed_external_osc_en_o        <= 1'b0;
         sysclk_src_o                       <= LPMC_SRC_MRC;
         main_reg_en_o                      <= 1'b1;
         lp_reg_en_o                        <= 1'b0;
         core_part_off_o                    <= 1'b0;
         core_supply_domain_off_o           <= 1'b0;
         first_ram_bank_keep_o              <= 1'b1;
         second_ram_bank_keep_o             <= 1'b1;
         converter_smps_o                   <= 1'b0; // R20
         programmable_voltage_detector_en_o <= 1'b0;
         vdet_lowest_o                      <= 1'b0;
         supply_mon_en_o                    <= 1'b1;
         rtc_en_o                           <= 1'b0;
         radio_en_o                         <= 1'b0;
      end
      else
      begin
         mode_o                      <= state_d;
         cpu_clk_en_o                <= run_like; // R2
         core_clk_en_o               <= run_like | sleep_like; // R2 R5
         // Fast oscillators stop in Stop, Standby and Shutdown, except the 16 MHz RC on a Stop wakeup request
         pll_en_o                    <= 1'b0;
         multispeed_internal_rc_en_o <= !fast_off && !(waking && exit_hsi_q && !wake_deep); // R5
         internal_16mhz_rc_en_o      <= fast_off ? (stop_next & wake_hsi_req_i) // R6
                                               : (waking ? (exit_hsi_q & !wake_deep)
                                                         : internal_16mhz_rc_en_o);
         external_32mhz_osc_en_o     <= 1'b0;
         low_speed_internal_rc_en_o  <= shut_next ? 1'b0 : slow_rc_keep_i; // R14
         low_speed_external_osc_en_o <= slow_xo_keep_i; // R14
         // Exit clock choice, deep modes force the 4 MHz multispeed RC
         if (waking)
         begin
            if (wake_deep)
            begin
               sysclk_src_o <= LPMC_SRC_MRC; // R13 R15
               mrc_range_o  <= LPMC_MRC_4MHZ; // R13 R15
            end
            else if (lp_origin_q)
               sysclk_src_o <= exit_hsi_q ? LPMC_SRC_RC16 : LPMC_SRC_MRC; // R8 R10
            // Converter back to the retained choice, not after Shutdown
            if (prev_q != LPMC_SHUTDOWN)
               converter_smps_o <= ret_q[0]; // R19
         end
         else if (fast_off)
            sysclk_src_o <= LPMC_SRC_NONE;
         // Regulators
         main_reg_en_o   <= !lp_regime && (run_like || sleep_like || state_d == LPMC_STOP0); // R7
         lp_reg_en_o     <= lp_regime || (state_d inside {LPMC_STOP1, LPMC_STOP2})
                            || retain_b2; // R3 R7 R11
         core_part_off_o          <= (state_d == LPMC_STOP2); // R9
         core_supply_domain_off_o <= down_next; // R11 R14
         first_ram_bank_keep_o    <= !down_next; // R5 R9
         second_ram_bank_keep_o   <= !down_next || retain_b2; // R11
         // Monitors
         programmable_voltage_detector_en_o <= vdet_en_i && !shut_next; // R12 R16
         vdet_lowest_o                      <= vdet_en_i && stby_next; // R12
         supply_mon_en_o                    <= !shut_next; // R16
         rtc_en_o   <= rtc_keep_i && !shut_next; // R17
         radio_en_o <= radio_keep_i && !shut_next; // R18
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_RESET_RUN: assert property (@(posedge clock_i) // R1
      !rstn_i |=> mode_o == LPMC_RUN && range_o == LPMC_RANGE1)
      else $error("Reset did not land in Run");
   AST_SLEEP_CPU: assert property (@(posedge clock_i) disable iff (!rstn_i) // R2
      mode_o == LPMC_SLEEP |-> !cpu_clk_en_o && core_clk_en_o)
      else $error("Sleep clock gating wrong");
   AST_SLOWRUN_REG: assert property (@(posedge clock_i) disable iff (!rstn_i) // R3
      mode_o == LPMC_LP_RUN |-> lp_reg_en_o && !main_reg_en_o)
      else $error("Low-power run regulator wrong");
   AST_SLOWSLEEP_FROM: assert property (@(posedge clock_i) disable iff (!rstn_i) // R4
      state_q == LPMC_LP_SLEEP && $past(state_q) != LPMC_LP_SLEEP
      |-> $past(state_q) == LPMC_LP_RUN)
      else $error("Low-power sleep from wrong mode");
   AST_STOP_OSC: assert property (@(posedge clock_i) disable iff (!rstn_i) // R5
      is_stop(mode_o) |-> !pll_en_o && !multispeed_internal_rc_en_o
                          && !external_32mhz_osc_en_o && first_ram_bank_keep_o)
      else $error("Stop oscillators not stopped");
   AST_STOP0_MAIN: assert property (@(posedge clock_i) disable iff (!rstn_i) // R7
      mode_o == LPMC_STOP0 |-> main_reg_en_o && !lp_reg_en_o)
      else $error("Stop 0 main regulator off");
   AST_STBY_RET: assert property (@(posedge clock_i) disable iff (!rstn_i) // R11
      mode_o == LPMC_STANDBY |-> second_ram_bank_keep_o == lp_reg_en_o && !main_reg_en_o)
      else $error("Standby retention wrong");
   AST_DEEP_EXIT: assert property (@(posedge clock_i) disable iff (!rstn_i) // R13
      state_q == LPMC_WAKE && $past(state_q) inside {LPMC_STANDBY, LPMC_SHUTDOWN}
      |=> sysclk_src_o == LPMC_SRC_MRC && mrc_range_o == LPMC_MRC_4MHZ)
      else $error("Deep exit clock not 4 MHz multispeed RC");
   AST_SHUT_MON: assert property (@(posedge clock_i) disable iff (!rstn_i) // R14
      mode_o == LPMC_SHUTDOWN |-> !supply_mon_en_o && !low_speed_internal_rc_en_o)
      else $error("Shutdown monitor or slow RC active");
   AST_WAKE: assert property (@(posedge clock_i) disable iff (!rstn_i) // R21
      in_lp && wake_hit |=> state_q == LPMC_WAKE ##1 state_q inside {LPMC_RUN, LPMC_LP_RUN})
      else $error("Wakeup did not return to run");

endmodule

// >>> sim/lpmc_bench.sv
// Self-checking testbench for the low-power mode sequencer
`timescale 1ns/1ps

module lpmc_bench;
   import lpmc_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic                  clock_i, rstn_i, mode_req_i, wake_on_hsi_i, wake_hsi_req_i;
   logic [3:0]            mode_sel_i;
   logic [15:0]           sysclk_khz_i;
   logic                  standby_ram_retain_bit_i, vdet_en_i, rtc_keep_i, radio_keep_i;
   logic                  slow_xo_keep_i, slow_rc_keep_i, converter_select_bit_i, converter_wr_i;
   logic [LPMC_NWAKE-1:0] wake_src_i, wake_en_i;
   lpmc_state_t           mode_o;
   logic                  cpu_clk_en_o, core_clk_en_o, range_o, pll_en_o, mrc_en_o;
   logic [3:0]            mrc_range_o;
   logic                  hsi_en_o, hse_en_o, slrc_en_o, slxo_en_o;
   logic [1:0]            sysclk_src_o;
   logic                  main_reg_en_o, lp_reg_en_o, core_part_off_o, core_off_o;
   logic                  ram1_keep_o, ram2_keep_o, converter_smps_o, vdet_en_o;
   logic                  vdet_lowest_o, supply_mon_en_o, rtc_en_o, radio_en_o;
   int                    fail_count = 0;
   int                    comparisons = 0;

   lpmc_top i_lpmc_top (
      .clock_i(clock_i), .rstn_i(rstn_i), .mode_req_i(mode_req_i), .mode_sel_i(mode_sel_i),
      .wake_on_hsi_i(wake_on_hsi_i), .sysclk_khz_i(sysclk_khz_i),
      .standby_ram_retain_bit_i(standby_ram_retain_bit_i), .vdet_en_i(vdet_en_i),
      .rtc_keep_i(rtc_keep_i), .radio_keep_i(radio_keep_i), .slow_xo_keep_i(slow_xo_keep_i),
      .slow_rc_keep_i(slow_rc_keep_i), .converter_select_bit_i(converter_select_bit_i),
      .converter_wr_i(converter_wr_i), .wake_src_i(wake_src_i), .wake_en_i(wake_en_i),
      .wake_hsi_req_i(wake_hsi_req_i), .mode_o(mode_o), .cpu_clk_en_o(cpu_clk_en_o),
      .core_clk_en_o(core_clk_en_o), .range_o(range_o), .pll_en_o(pll_en_o),
      .multispeed_internal_rc_en_o(mrc_en_o), .mrc_range_o(mrc_range_o),
      .internal_16mhz_rc_en_o(hsi_en_o), .external_32mhz_osc_en_o(hse_en_o),
      .low_speed_internal_rc_en_o(slrc_en_o), .low_speed_external_osc_en_o(slxo_en_o),
      .sysclk_src_o(sysclk_src_o), .main_reg_en_o(main_reg_en_o), .lp_reg_en_o(lp_reg_en_o),
      .core_part_off_o(core_part_off_o), .core_supply_domain_off_o(core_off_o),
      .first_ram_bank_keep_o(ram1_keep_o), .second_ram_bank_keep_o(ram2_keep_o),
      .converter_smps_o(converter_smps_o), .programmable_voltage_detector_en_o(vdet_en_o),
      .vdet_lowest_o(vdet_lowest_o), .supply_mon_en_o(supply_mon_en_o), .rtc_en_o(rtc_en_o),
      .radio_en_o(radio_en_o));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Reset is synchronous, so it is held across several edges
   task automatic do_reset;
      rstn_i = 1'b0;
      repeat (8) @(negedge clock_i);
      rstn_i = 1'b1;
   endtask

   // One-cycle request pulse, low for a cycle first; outputs have landed on return
   task automatic request(input logic [3:0] sel);
      @(negedge clock_i);
      mode_sel_i = sel;
      mode_req_i = 1'b1;
      @(negedge clock_i);
      mode_req_i = 1'b0;
   endtask

   // One-cycle wakeup pulse; the sequencer then sits in its wake state
   task automatic wake_up(input logic [LPMC_NWAKE-1:0] src);
      @(negedge clock_i);
      wake_src_i = src;
      @(negedge clock_i);
      wake_src_i = '0;
   endtask

   // Writes the retained converter choice and standby RAM bit
   task automatic write_ret(input logic conv, input logic retain);
      converter_select_bit_i = conv;
      standby_ram_retain_bit_i = retain;
      converter_wr_i = 1'b1;
      @(negedge clock_i);
      converter_wr_i = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      check(16'(mode_o), 16'(LPMC_RUN));
      check(16'(range_o), 16'(LPMC_RANGE1));
      check(16'(converter_smps_o), 16'h0000);
      check(16'(cpu_clk_en_o), 16'h0001);
   endtask

   // Unenabled source must not wake; enabled one wakes through the wake state
   task automatic t_sleep;
      request(LPMC_REQ_SLEEP);
      check(16'(mode_o), 16'(LPMC_SLEEP));
      check({cpu_clk_en_o, core_clk_en_o}, 16'h0001);
      wake_up(8'h02);
      check(16'(mode_o), 16'(LPMC_SLEEP));
      wake_up(8'h01);
      check(16'(mode_o), 16'(LPMC_WAKE));
      @(negedge clock_i);
      check(16'(mode_o), 16'(LPMC_RUN));
   endtask

   // Boundary of the 2 MHz ceiling and the entry order of low-power sleep
   task automatic t_lp;
      sysclk_khz_i = LPMC_SLOW_MAX;
      request(LPMC_REQ_LP_SLEEP);
      check(16'(mode_o), 16'(LPMC_RUN));
      request(LPMC_REQ_LP_RUN);
      check(16'(mode_o), 16'(LPMC_RUN));
      sysclk_khz_i = LPMC_SLOW_MAX - 16'h0001;
      request(LPMC_REQ_LP_RUN);
      check(16'(mode_o), 16'(LPMC_LP_RUN));
      check({main_reg_en_o, lp_reg_en_o}, 16'h0001);
      request(LPMC_REQ_LP_SLEEP);
      check(16'(mode_o), 16'(LPMC_LP_SLEEP));
      request(LPMC_REQ_RUN);
      check(16'(mode_o), 16'(LPMC_LP_SLEEP));
      wake_up(8'h01);
      @(negedge clock_i);
      check(16'(mode_o), 16'(LPMC_LP_RUN));
      sysclk_khz_i = LPMC_SLOW_MAX;
      @(negedge clock_i);
      check(16'(mode_o), 16'(LPMC_RUN));
   endtask

   // Stop variants: regulator, oscillators, retention and exit clock
   task automatic t_stop(input logic [3:0] sel, input lpmc_state_t st, input logic main,
                         input logic part_off, input logic hsi, input logic conv);
      wake_on_hsi_i = hsi;
      rtc_keep_i = hsi;
      radio_keep_i = ~hsi;
      request(sel);
      check(16'(mode_o), 16'(st));
      check({main_reg_en_o, lp_reg_en_o}, {14'h0, main, ~main});
      check({pll_en_o, mrc_en_o, hsi_en_o, hse_en_o}, 16'h0000);
      check({slrc_en_o, slxo_en_o, ram1_keep_o, ram2_keep_o}, 16'h000f);
      check(16'(core_part_off_o), 16'(part_off));
      check({rtc_en_o, radio_en_o}, {14'h0, hsi, ~hsi});
      wake_hsi_req_i = 1'b1;
      @(negedge clock_i);
      wake_hsi_req_i = 1'b0;
      check(16'(hsi_en_o), 16'h0001);
      wake_up(8'h01);
      check(16'(mode_o), 16'(LPMC_WAKE));
      @(negedge clock_i);
      check(16'(mode_o), 16'(LPMC_RUN));
      check(16'(sysclk_src_o), 16'(hsi ? LPMC_SRC_RC16 : LPMC_SRC_MRC));
      check(16'(converter_smps_o), 16'(conv));
   endtask

   // Standby with and without second bank retention
   task automatic t_standby(input logic retain);
      write_ret(1'b0, retain);
      vdet_en_i = 1'b1;
      request(LPMC_REQ_STANDBY);
      check(16'(mode_o), 16'(LPMC_STANDBY));
      check({core_off_o, ram2_keep_o, lp_reg_en_o, main_reg_en_o},
            {12'h0, 1'b1, retain, retain, 1'b0});
      check({vdet_en_o, vdet_lowest_o}, 16'h0003);
      wake_up(8'h01);
      @(negedge clock_i);
      check({sysclk_src_o, mrc_range_o}, {10'h0, LPMC_SRC_MRC, LPMC_MRC_4MHZ});
      check(16'(converter_smps_o), 16'h0000);
      vdet_en_i = 1'b0;
   endtask

   // Shutdown keeps only the slow crystal and drops supply monitoring
   task automatic t_shutdown;
      vdet_en_i = 1'b1;
      request(LPMC_REQ_SHUTDOWN);
      check(16'(mode_o), 16'(LPMC_SHUTDOWN));
      check({slrc_en_o, slxo_en_o, core_off_o}, 16'h0003);
      check({supply_mon_en_o, vdet_en_o}, 16'h0000);
      wake_up(8'h01);
      @(negedge clock_i);
      check({sysclk_src_o, mrc_range_o}, {10'h0, LPMC_SRC_MRC, LPMC_MRC_4MHZ});
      check(16'(supply_mon_en_o), 16'h0001);
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // Cuts a hang short well inside the cycle budget
   initial
   begin
      repeat (20000) @(posedge clock_i);
      fail_count++;
      finish_test();
   end

   initial
   begin
      rstn_i = 1'b0; mode_req_i = 1'b0; mode_sel_i = LPMC_REQ_NONE;
      wake_on_hsi_i = 1'b0; wake_hsi_req_i = 1'b0; sysclk_khz_i = 16'h3e80;
      standby_ram_retain_bit_i = 1'b0; vdet_en_i = 1'b0; rtc_keep_i = 1'b0;
      radio_keep_i = 1'b0; slow_xo_keep_i = 1'b1; slow_rc_keep_i = 1'b1;
      converter_select_bit_i = 1'b0; converter_wr_i = 1'b0;
      wake_src_i = '0; wake_en_i = 8'h01;
      @(negedge clock_i);
      do_reset();
      t_reset();
      t_sleep();
      t_lp();
      write_ret(1'b1, 1'b0);
      t_stop(LPMC_REQ_STOP0, LPMC_STOP0, 1'b1, 1'b0, 1'b0, 1'b1);
      t_stop(LPMC_REQ_STOP1, LPMC_STOP1, 1'b0, 1'b0, 1'b1, 1'b1);
      t_stop(LPMC_REQ_STOP2, LPMC_STOP2, 1'b0, 1'b1, 1'b0, 1'b1);
      t_standby(1'b1);
      t_standby(1'b0);
      t_shutdown();
      // A pin reset in mid-run must drop the stored converter choice
      write_ret(1'b1, 1'b0);
      do_reset();
      t_reset();
      // The cleared choice must show on the next exit from Stop
      t_stop(LPMC_REQ_STOP1, LPMC_STOP1, 1'b0, 1'b0, 1'b0, 1'b0);
      finish_test();
   end

endmodule
